// File: csl_checker.sv
module csl_chk
	import csl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic rx_present,
	input wire logic rx_power_req,
	input wire logic [PWR_W-1:0] rx_req_level,
	input wire logic fod_detect,
	input wire logic power_en,
	input wire logic [PWR_W-1:0] power_level,
	input wire logic led_green,
	input wire logic led_red,
	input wire logic [2:0] state_code
);
	timeunit 1ns;
	timeprecision 1ns;
	// ========
	// Port-level relations, one clock domain
	// ========
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	sequence s_fod;
		state_code == 3'h3 && fod_detect && rx_present;
	endsequence
	property p_init; state_code == 3'h0 |-> led_green && !led_red && !power_en; endproperty
	a_init: assert property (p_init) else $error("init lamps wrong");
	property p_idle; state_code == 3'h1 |-> !led_green && !led_red && !power_en; endproperty
	a_idle: assert property (p_idle) else $error("standby not dark");
	// Grant needs charging and a receiver seen one cycle earlier
	property p_pow; power_en |-> state_code == 3'h3 && $past(rx_present); endproperty
	a_pow: assert property (p_pow) else $error("power without receiver");
	property p_lvl; !power_en |-> power_level == 8'h00; endproperty
	a_lvl: assert property (p_lvl) else $error("level while off");
	property p_req;
		state_code == 3'h3 && rx_power_req && rx_present |=>
			state_code != 3'h3 || power_level == $past(rx_req_level);
	endproperty
	a_req: assert property (p_req) else $error("request level not taken");
	property p_fod; s_fod |=> state_code == 3'h4 && !power_en && !led_green; endproperty
	a_fod: assert property (p_fod) else $error("foreign object not aborted");
	property p_flt; state_code == 3'h5 |-> led_red && !led_green && !power_en; endproperty
	a_flt: assert property (p_flt) else $error("fault lamps wrong");
	property p_done; state_code == 3'h6 |-> led_green && !led_red && !power_en; endproperty
	a_done: assert property (p_done) else $error("complete lamps wrong");
	property p_gone; state_code > 3'h1 && !rx_present |=> state_code == 3'h1; endproperty
	a_gone: assert property (p_gone) else $error("removal missed");
endmodule

bind csl_fsm csl_chk i_chk (.*);

// File: csl_fsm.sv
// Functional notes
// R1 - Power-up init: green on half second, standby
// R2 - Standby keeps both indicators off
// R3 - Power only after receiver found and configured
// R4 - Grant only requested level, receiver present
// R5 - Charging blinks green, one second period
// R6 - Requests stop: terminate the transaction
// R7 - Foreign object: abort, red blinks till removal
// R8 - Other error: abort, steady red till removal
// R9 - Errors: comm failure, any over-limit flag
// R10 - No further power: drop output
// R11 - No further power: steady green till removal
// R12 - Removal returns to standby from any state; CSL_INIT does not check rx_present and leaves only when its hold ends
// R13 - Standby emits short ping several times/second
// R14 - Intervals from prescaled timebase, restarted on entry
module csl_fsm
	import csl_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic rx_present,
	input wire logic rx_config_valid,
	input wire logic [PWR_W-1:0] rx_config_level,
	input wire logic rx_power_req,
	input wire logic [PWR_W-1:0] rx_req_level,
	input wire logic rx_end_power,
	input wire logic fod_detect,
	input wire logic comm_error,
	input wire logic rx_over_volt,
	input wire logic rx_over_curr,
	input wire logic rx_over_pwr,
	input wire logic rx_over_temp,
	input wire logic tx_over_volt,
	input wire logic tx_over_curr,
	input wire logic tx_over_pwr,
	input wire logic tx_over_temp,
	output logic ping_en,
	output logic power_en,
	output logic [PWR_W-1:0] power_level,
	output logic led_green,
	output logic led_red,
	output logic [2:0] state_code
);

	// ==========================================
	// State and timers
	// ==========================================
	csl_state_t state_q, state_d;
	logic [MS_W-1:0] ms_q, ms_d;
	logic [MS_W-1:0] req_ms_q, req_ms_d;
	logic [PWR_W-1:0] level_q, level_d;
	logic pwr_q, pwr_d;
	logic ping_q, ping_d;
	logic grn_q, grn_d;
	logic red_q, red_d;
	logic enter;
	logic tick;
	logic any_error;

	// Restarting the prescaler on entry keeps every hold timed from state entry exact; request resets of the watchdog are not realigned
	csl_timebase #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timebase (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.restart(enter),
		.tick(tick)
	); // [R14]

	// Error sources, all treated alike
	assign any_error = comm_error | rx_over_volt | rx_over_curr | rx_over_pwr |
		rx_over_temp | tx_over_volt | tx_over_curr | tx_over_pwr | tx_over_temp; // [R9]

	// ==========================================
	// Next state
	// ==========================================
	always_comb begin
		state_d = state_q;
		case (state_q)
			CSL_INIT: begin
				if (ms_q >= INIT_HOLD_MS) begin
					state_d = CSL_STANDBY; // [R1]
				end
			end
			CSL_STANDBY: begin
				// Only a reply during our own ping counts as a find
				if (ping_q && rx_present) begin
					state_d = CSL_IDENT; // [R3]
				end
			end
			CSL_IDENT: begin
				if (!rx_present) begin
					state_d = CSL_STANDBY; // [R12]
				end else if (any_error) begin
					state_d = CSL_FAULT; // [R8]
				end else if (rx_config_valid) begin
					state_d = CSL_CHARGE; // [R3]
				end else if (ms_q >= IDENT_TIMEOUT_MS) begin
					state_d = CSL_STANDBY;
				end
			end
			CSL_CHARGE: begin
				// Removal first, then faults, then normal ending
				if (!rx_present) begin
					state_d = CSL_STANDBY; // [R12]
				end else if (fod_detect) begin
					state_d = CSL_FOD; // [R7]
				end else if (any_error) begin
					state_d = CSL_FAULT; // [R8]
				end else if (rx_end_power) begin
					state_d = CSL_DONE; // [R11]
				end else if (req_ms_q >= REQ_TIMEOUT_MS && !rx_power_req) begin
					state_d = CSL_STANDBY; // [R6]
				end
			end
			CSL_FOD, CSL_FAULT, CSL_DONE: begin
				if (!rx_present) begin
					state_d = CSL_STANDBY; // [R12]
				end
			end
			default: begin
				state_d = CSL_INIT;
			end
		endcase
	end

	assign enter = (state_d != state_q);

	// ==========================================
	// Millisecond timers
	// ==========================================
	always_comb begin
		ms_d = ms_q;
		req_ms_d = req_ms_q;
		if (enter) begin
			ms_d = '0; // [R14]
		end else if (tick) begin
			// Wrapping states loop; others saturate so holds never alias
			if ((state_q == CSL_CHARGE || state_q == CSL_FOD) &&
				ms_q == BLINK_PERIOD_MS - 12'h001) begin
				ms_d = '0; // [R5]
			end else if (state_q == CSL_STANDBY && ms_q == PING_PERIOD_MS - 12'h001) begin
				ms_d = '0; // [R13]
			end else if (ms_q != {MS_W{1'b1}}) begin
				ms_d = ms_q + 12'h001;
			end
		end
		// Silence watchdog on receiver requests
		if (enter || rx_power_req) begin
			req_ms_d = '0; // [R6]
		end else if (tick && req_ms_q != {MS_W{1'b1}}) begin
			req_ms_d = req_ms_q + 12'h001;
		end
	end

	// ==========================================
	// Power grant and indicators
	// ==========================================
	always_comb begin
		level_d = level_q;
		pwr_d = 1'b0;
		ping_d = 1'b0;
		grn_d = 1'b0;
		red_d = 1'b0;
		case (state_d)
			CSL_INIT: begin
				grn_d = 1'b1; // [R1]
				level_d = PWR_OFF;
			end
			CSL_STANDBY: begin
				// Both indicators dark to save power
				ping_d = (ms_d < PING_WIDTH_MS); // [R2] [R13]
				level_d = PWR_OFF;
			end
			CSL_IDENT: begin
				// Keep the reply energy alive while the receiver configures
				ping_d = 1'b1;
				level_d = PWR_OFF;
			end
			CSL_CHARGE: begin
				// Config level is only valid in the cycle that reports it
				if (rx_power_req) begin
					level_d = rx_req_level; // [R4]
				end else if (state_q == CSL_IDENT) begin
					level_d = rx_config_level; // [R3]
				end
				pwr_d = rx_present; // [R4]
				grn_d = (ms_d < BLINK_ON_MS); // [R5]
			end
			CSL_FOD: begin
				red_d = (ms_d < BLINK_ON_MS); // [R7]
				level_d = PWR_OFF;
			end
			CSL_FAULT: begin
				red_d = 1'b1; // [R8]
				level_d = PWR_OFF;
			end
			CSL_DONE: begin
				grn_d = 1'b1; // [R11]
				level_d = PWR_OFF; // [R10]
			end
			default: begin
				level_d = PWR_OFF;
			end
		endcase
	end

	// All state registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= CSL_INIT;
			ms_q <= '0;
			req_ms_q <= '0;
			level_q <= PWR_OFF;
			pwr_q <= 1'b0;
			ping_q <= 1'b0;
			grn_q <= 1'b1;
			red_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ms_q <= ms_d;
			req_ms_q <= req_ms_d;
			level_q <= level_d;
			pwr_q <= pwr_d;
			ping_q <= ping_d;
			grn_q <= grn_d;
			red_q <= red_d;
		end
	end

	// Level is forced to zero whenever no grant is active
	assign power_en = pwr_q;
	assign power_level = pwr_q ? level_q : PWR_OFF; // [R4]
	assign ping_en = ping_q;
	assign led_green = grn_q;
	assign led_red = red_q;
	assign state_code = state_q;

endmodule

// File: csl_pkg.sv
package csl_pkg;

	// ==========================================
	// Clock and timebase
	// ==========================================
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_US = 1000;
	// Cycles per 1 ms tick, derived from the clock rate
	localparam int TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
	localparam int TICK_CNT_W = 16;

	// ==========================================
	// Intervals in milliseconds
	// ==========================================
	localparam int MS_W = 12;
	localparam logic [MS_W-1:0] INIT_HOLD_MS = 12'h1f4;
	localparam logic [MS_W-1:0] BLINK_PERIOD_MS = 12'h3e8;
	localparam logic [MS_W-1:0] BLINK_ON_MS = 12'h1f4;
	localparam logic [MS_W-1:0] PING_PERIOD_MS = 12'h0fa;
	localparam logic [MS_W-1:0] PING_WIDTH_MS = 12'h001;
	localparam logic [MS_W-1:0] IDENT_TIMEOUT_MS = 12'h5dc;
	localparam logic [MS_W-1:0] REQ_TIMEOUT_MS = 12'h5dc;

	// ==========================================
	// Power level and states
	// ==========================================
	localparam int PWR_W = 8;
	localparam logic [PWR_W-1:0] PWR_OFF = 8'h00;

	typedef enum logic [2:0] {
		CSL_INIT,
		CSL_STANDBY,
		CSL_IDENT,
		CSL_CHARGE,
		CSL_FOD,
		CSL_FAULT,
		CSL_DONE
	} csl_state_t;

endpackage

// File: csl_rx.sv
module csl_rx
	import csl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic placed,
	input wire logic req_on,
	input wire logic full,
	input wire logic [PWR_W-1:0] lvl,
	input wire logic ping_en,
	output logic rx_present,
	output logic rx_config_valid,
	output logic [PWR_W-1:0] rx_config_level,
	output logic rx_power_req,
	output logic [PWR_W-1:0] rx_req_level,
	output logic rx_end_power
);
	timeunit 1ns;
	timeprecision 1ns;
	logic seen_q;
	logic [6:0] cnt_q;
	// ========
	// Receiver wakes only on a ping, then reports
	// ========
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			seen_q <= 1'b0;
			cnt_q <= 7'h00;
		end else begin
			seen_q <= placed && (seen_q || ping_en);
			cnt_q <= (cnt_q == 7'h63) ? 7'h00 : cnt_q + 7'h01;
		end
	end
	// Request every 100 cycles; level garbage between requests
	assign rx_present = placed;
	assign rx_config_valid = seen_q;
	assign rx_config_level = seen_q ? lvl : ~lvl;
	assign rx_power_req = req_on && seen_q && cnt_q == 7'h00;
	assign rx_req_level = rx_power_req ? lvl : {1'b0, cnt_q};
	assign rx_end_power = full && seen_q;
endmodule

// File: csl_timebase.sv
// ==========================================
// Millisecond tick divider
// ==========================================
module csl_timebase
	import csl_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic restart,
	output logic tick
);

	logic [TICK_CNT_W-1:0] cnt_q, cnt_d;
	logic tick_q, tick_d;

	// Restart realigns the tick to the state entry
	always_comb begin
		cnt_d = cnt_q + 16'h0001;
		tick_d = 1'b0;
		if (restart) begin
			cnt_d = '0;
		end else if (cnt_q == TICK_CNT_W'(TICK_CYCLES - 1)) begin
			cnt_d = '0;
			tick_d = 1'b1;
		end
	end

	// Registers only
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule

// File: testbench.sv
module testbench
	import csl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic placed = 1'b0;
	logic req_on = 1'b0;
	logic full = 1'b0;
	logic fod_detect = 1'b0;
	logic [8:0] err = 9'h000;
	logic [PWR_W-1:0] lvl = 8'h5a;
	logic comm_error, rx_over_volt, rx_over_curr, rx_over_pwr, rx_over_temp;
	logic tx_over_volt, tx_over_curr, tx_over_pwr, tx_over_temp;
	logic rx_present, rx_config_valid, rx_power_req, rx_end_power;
	logic [PWR_W-1:0] rx_config_level, rx_req_level, power_level;
	logic ping_en, power_en, led_green, led_red;
	logic [2:0] state_code;
	int miscompares = 0;
	int cmp_count = 0;
	int n, g, r;
	// ========
	// Clock, error fan-out, design and receiver
	// ========
	always #50 ref_clk = ~ref_clk;
	assign {comm_error, rx_over_volt, rx_over_curr, rx_over_pwr, rx_over_temp} = err[8:4];
	assign {tx_over_volt, tx_over_curr, tx_over_pwr, tx_over_temp} = err[3:0];
	// Short tick keeps the long intervals cheap: 1 ms is 2 cycles
	csl_fsm #(.TICK_CYCLES(2)) i_dut (.*);
	csl_rx i_rx (.*);
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk);
		#10;
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] v);
		cmp_count++;
		if (v !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", s, e, v);
		end
	endtask
	// Bounded wait; n holds cycles spent
	task automatic wait_st(input logic [2:0] s);
		n = 0;
		while (state_code !== s && n < 4000) begin
			step(1);
			n++;
		end
		// A wait that runs out is a mismatch of its own
		if (state_code !== s) begin
			miscompares++;
			$display("BAD wait state exp %h got %h", s, state_code);
		end
	endtask
	// Window of one full blink period
	task automatic blink();
		g = 0;
		r = 0;
		repeat (2000) begin
			step(1);
			g += led_green;
			r += led_red;
		end
	endtask
	task automatic go_charge();
		placed = 1'b1;
		req_on = 1'b1;
		wait_st(3'h3);
		chk("charge", 8'h03, state_code);
	endtask
	task automatic leave();
		placed = 1'b0;
		req_on = 1'b0;
		full = 1'b0;
		wait_st(3'h1);
		chk("standby", 8'h01, state_code);
		chk("power off", 8'h00, power_en);
	endtask
	task automatic t_init();
		chk("init green", 8'h01, led_green);
		wait_st(3'h1);
		chk("init span", 8'h01, n >= 995 && n <= 1010);
		chk("dark", 8'h00, {led_green, led_red});
		g = 0;
		repeat (1000) begin
			step(1);
			g += ping_en;
		end
		chk("ping cycles", 8'h04, 8'(g));
		$display("test init done");
	endtask
	task automatic t_charge();
		go_charge();
		chk("cfg level", 8'h5a, power_level);
		lvl = 8'h33;
		step(120);
		chk("req level", 8'h33, power_level);
		blink();
		chk("green blink", 8'h01, g >= 995 && g <= 1005);
		full = 1'b1;
		step(2);
		chk("complete", 8'h06, state_code);
		chk("level down", 8'h00, power_level);
		leave();
		$display("test charge done");
	endtask
	task automatic t_stop();
		go_charge();
		req_on = 1'b0;
		wait_st(3'h1);
		chk("req timeout", 8'h01, n >= 2900 && n <= 3010);
		chk("no power", 8'h00, power_en);
		leave();
		$display("test stop done");
	endtask
	task automatic t_faults();
		go_charge();
		fod_detect = 1'b1;
		step(1);
		fod_detect = 1'b0;
		chk("fod state", 8'h04, state_code);
		blink();
		chk("red blink", 8'h01, r >= 995 && r <= 1005 && g == 0);
		leave();
		for (int i = 0; i < 9; i++) begin
			go_charge();
			err = 9'h001 << i;
			step(1);
			err = 9'h000;
			step(5);
			chk("fault state", 8'h05, state_code);
			chk("red steady", 8'h01, led_red);
			leave();
		end
		$display("test faults done");
	endtask
	task automatic tally_and_finish();
		$display("TB: %0d compares, %0d mismatches", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Main sequence after six reset cycles
	initial begin
		step(6);
		rst_b = 1'b1;
		t_init();
		t_charge();
		t_stop();
		t_faults();
		tally_and_finish();
	end
	// Watchdog well past the expected run
	initial begin
		repeat (60000) @(posedge ref_clk);
		miscompares++;
		tally_and_finish();
	end
endmodule
